// *** fwp_pkg.sv ***
// shared constants of the flash write-protection link
package fwp_pkg;
	localparam int CORE_MHZ = 50;
	// command opcodes
	localparam logic [7:0] OP_SET_WE = 8'h06;
	localparam logic [7:0] OP_CLR_WE = 8'h04;
	localparam logic [7:0] OP_READ_SR1 = 8'h05;
	localparam logic [7:0] OP_READ_SR2 = 8'h35;
	localparam logic [7:0] OP_WRITE_SR = 8'h01;
	localparam logic [7:0] OP_PROGRAM = 8'h02;
	localparam logic [7:0] OP_ERASE_PAGE = 8'h81;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hd8;
	localparam logic [7:0] OP_ERASE_CHIP = 8'h60;
	localparam logic [7:0] OP_ERASE_CHIP2 = 8'hc7;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_DEEP_PD = 8'hb9;
	localparam logic [7:0] OP_RELEASE_PD = 8'hab;
	// command lengths in bits
	localparam logic [5:0] LEN_OP = 6'h08;
	localparam logic [5:0] LEN_SR1 = 6'h10;
	localparam logic [5:0] LEN_SR2 = 6'h18;
	localparam logic [5:0] LEN_ERASE = 6'h20;
	localparam logic [5:0] LEN_PROGRAM = 6'h28;
	localparam logic [5:0] LEN_OVER = 6'h3f;
	// array geometry
	localparam logic [23:0] ARRAY_BYTES = 24'h080000;
	localparam logic [23:0] ARRAY_TOP = 24'h07ffff;
	localparam logic [23:0] SIZE_64K = 24'h010000;
	localparam logic [23:0] SIZE_32K = 24'h008000;
	localparam logic [23:0] SIZE_4K = 24'h001000;
	localparam logic [23:0] MASK_PAGE = 24'h0000ff;
	localparam logic [23:0] MASK_4K = 24'h000fff;
	localparam logic [23:0] MASK_32K = 24'h007fff;
	localparam logic [23:0] MASK_64K = 24'h00ffff;
	// timing
	localparam int SUSPEND_LATENCY_US = 30;
	localparam int PROGRAM_TYP_MS = 2;
	localparam int PROGRAM_MAX_MS = 3;
	localparam int ERASE_TYP_MS = 16;
	localparam int ERASE_MAX_MS = 30;
	localparam int RESUME_GAP_US = 20;
	localparam int PROGRESS_GAP_US = 100;
	localparam int SELECT_DELAY_US = 150;
	localparam int SUSPEND_LATENCY_CYC = SUSPEND_LATENCY_US * CORE_MHZ;
	localparam int PROGRAM_CYC = PROGRAM_TYP_MS * 1000 * CORE_MHZ;
	localparam int PROGRAM_MAX_CYC = PROGRAM_MAX_MS * 1000 * CORE_MHZ;
	localparam int ERASE_CYC = ERASE_TYP_MS * 1000 * CORE_MHZ;
	localparam int ERASE_MAX_CYC = ERASE_MAX_MS * 1000 * CORE_MHZ;
	localparam int RESUME_GAP_CYC = RESUME_GAP_US * CORE_MHZ;
	localparam int PROGRESS_GAP_CYC = PROGRESS_GAP_US * CORE_MHZ;
	localparam int SELECT_DELAY_CYC = SELECT_DELAY_US * CORE_MHZ;
	localparam int SCLK_HALF_CYC = 8;
	// host register map
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ARGS = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam logic [3:0] REG_STATUS = 4'hc;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : fwp_pkg

// *** fwp_link_if.sv ***
// serial link between the flash end and its controller
`timescale 1ns/100ps
interface fwp_link_if;
	logic sclk;
	logic cs_n;
	logic mosi;
	logic miso;
	logic wp_n;
	modport flash (input sclk, input cs_n, input mosi, input wp_n, output miso);
	modport ctrl (output sclk, output cs_n, output mosi, output wp_n, input miso);
endinterface : fwp_link_if

// *** fwp_flash_end.sv ***
// flash end: command decode, write protection and program/erase timing
`timescale 1ns/100ps
// Operation
// - enter suspend within 30 us of suspend
// - host waits 20 us resume to program suspend
// - host waits 20 us resume to erase suspend
// - program loops need 100 us resume gaps
// - erase loops need 100 us resume gaps
// - page program finishes within 3 ms
// - every erase finishes within 30 ms
// - host waits 150 us after power-up
// - power-up returns state machine to standby
// - status reads zero as delivered
// - array changes only after complete commands
// - reject commands not ending on byte boundary
// - data-changing commands need write enable latch
// - protect bits select unwritable array region
// - low write-protect pin freezes protect bits
// - deep power-down ignores all but release; status reads still shift out on miso here
// - protect bits decode to fractional top/bottom range
// - complement bit inverts the protected range
// - program or erase touching protection ignored
// - per-block select protects whole array here
module fwp_flash_end
	import fwp_pkg::*;
#(
	parameter int PROG_CYCLES = PROGRAM_CYC,
	parameter int ERASE_CYCLES = ERASE_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// serial link
	fwp_link_if.flash link,
	// array update strobes
	output logic mem_prog,
	output logic [18:0] mem_prog_addr,
	output logic [7:0] mem_prog_data,
	output logic mem_erase,
	output logic [18:0] mem_erase_lo,
	output logic [18:0] mem_erase_hi,
	// state
	output logic busy,
	output logic suspended,
	output logic deep_pd
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_BUSY = 2'b01,
		ST_SUSP = 2'b10
	} fwp_dev_state_type;

	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic wp1;
		logic wp2;
		fwp_dev_state_type st;
		logic [5:0] nbits;
		logic [7:0] sh;
		logic [7:0] opcode;
		logic [31:0] args;
		logic [7:0] tx;
		logic miso;
		logic write_enable_latch;
		logic [4:0] protect_bits;
		logic srp0;
		logic srp1;
		logic cmp;
		logic per_block_protect_select;
		logic dpd;
		logic [19:0] timer;
		logic op_erase;
		logic [18:0] op_lo;
		logic [18:0] op_hi;
		logic [7:0] op_data;
		logic prog_pulse;
		logic erase_pulse;
	} fwp_dev_regs_type;

	fwp_dev_regs_type r;
	fwp_dev_regs_type n;

	// true when [lo,hi] overlaps the region the protect bits guard
	function automatic logic prot_hit(input logic [4:0] bp, input logic c, input logic w,
			input logic [23:0] lo, input logic [23:0] hi);
		logic none;
		logic all;
		logic swap;
		logic [23:0] size;
		logic [23:0] plo;
		logic [23:0] phi;
		none = (bp[2:0] == 3'h0);
		all = bp[4] ? (bp[2:0] == 3'h7) : bp[2];
		if (bp[4] && bp[2]) begin
			size = SIZE_32K;
		end else if (bp[4]) begin
			size = SIZE_4K << (bp[1:0] - 2'h1);
		end else begin
			size = SIZE_64K << (bp[1:0] - 2'h1);
		end
		if (bp[3]) begin
			plo = 24'h0;
			phi = size - 24'h1;
		end else begin
			plo = ARRAY_BYTES - size;
			phi = ARRAY_TOP;
		end
		if (c) begin
			if (bp[3]) begin
				plo = phi + 24'h1;
				phi = ARRAY_TOP;
			end else begin
				phi = plo - 24'h1;
				plo = 24'h0;
			end
			swap = none;
			none = all;
			all = swap;
		end
		// individual lock bits are all set after power-up and never cleared here
		return w || all || (!none && lo <= phi && hi >= plo);
	endfunction : prot_hit

	function automatic logic [23:0] erase_mask(input logic [7:0] op);
		case (op)
			OP_ERASE_PAGE: erase_mask = MASK_PAGE;
			OP_ERASE_4K: erase_mask = MASK_4K;
			OP_ERASE_32K: erase_mask = MASK_32K;
			default: erase_mask = MASK_64K;
		endcase
	endfunction : erase_mask

	logic rise;
	logic fall;
	logic cs_up;
	logic cs_down;
	logic len_ok;
	logic [7:0] byte_in;
	logic [7:0] sr1;
	logic [7:0] sr2;
	logic [23:0] t_lo;
	logic [23:0] t_hi;

	assign sr1 = {r.srp0, r.protect_bits, r.write_enable_latch, r.st == ST_BUSY};
	assign sr2 = {r.st == ST_SUSP, r.cmp, 3'h0, r.per_block_protect_select, 1'h0, r.srp1};

	always_comb begin
		n = r;
		n.prog_pulse = 1'b0;
		n.erase_pulse = 1'b0;
		n.s1 = {link.sclk, link.cs_n, link.mosi};
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.wp1 = link.wp_n;
		n.wp2 = r.wp1;
		rise = r.s2[2] && !r.s3[2] && !r.s2[1];
		fall = !r.s2[2] && r.s3[2] && !r.s2[1];
		cs_up = r.s2[1] && !r.s3[1];
		cs_down = !r.s2[1] && r.s3[1];
		byte_in = {r.sh[6:0], r.s2[0]};
		// a command that stopped mid-byte or overflowed the counter is dropped
		len_ok = (r.nbits[2:0] == 3'h0) && (r.nbits != 6'h0) && (r.nbits < LEN_OVER);
		t_lo = r.args[23:0] & ~erase_mask(r.opcode);
		t_hi = r.args[23:0] | erase_mask(r.opcode);
		if (cs_down) begin
			n.nbits = 6'h0;
		end
		if (rise) begin
			n.sh = byte_in;
			if (r.nbits != LEN_OVER) begin
				n.nbits = r.nbits + 6'h1;
			end
			if (r.nbits == LEN_OP - 6'h1) begin
				n.opcode = byte_in;
				n.tx = (byte_in == OP_READ_SR2) ? sr2 : sr1;
			end else if (r.nbits[2:0] == 3'h7) begin
				n.args = {r.args[23:0], byte_in};
			end
		end
		if (fall) begin
			n.miso = r.tx[7];
			n.tx = {r.tx[6:0], r.tx[7]};
		end
		if (r.st == ST_BUSY) begin
			if (r.timer == 20'h0) begin
				n.st = ST_IDLE;
				n.prog_pulse = !r.op_erase;
				n.erase_pulse = r.op_erase;
			end else begin
				n.timer = r.timer - 20'h1;
			end
		end
		// commands act only when chip select returns high after whole bytes
		if (cs_up && len_ok) begin
			if (r.dpd) begin
				if (r.opcode == OP_RELEASE_PD && r.nbits == LEN_OP) begin
					n.dpd = 1'b0;
				end
			end else begin
				case (r.st)
					ST_BUSY: begin
						// the timer freezes at once, well inside the latency bound
						if (r.opcode == OP_SUSPEND && r.nbits == LEN_OP) begin
							n.st = ST_SUSP;
						end
					end
					ST_SUSP: begin
						if (r.opcode == OP_RESUME && r.nbits == LEN_OP) begin
							n.st = ST_BUSY;
						end
					end
					default: begin
						case (r.opcode)
							OP_SET_WE: begin
								if (r.nbits == LEN_OP) begin
									n.write_enable_latch = 1'b1;
								end
							end
							OP_CLR_WE: begin
								if (r.nbits == LEN_OP) begin
									n.write_enable_latch = 1'b0;
								end
							end
							OP_DEEP_PD: begin
								if (r.nbits == LEN_OP) begin
									n.dpd = 1'b1;
								end
							end
							OP_WRITE_SR: begin
								if (r.write_enable_latch && (r.nbits == LEN_SR1 || r.nbits == LEN_SR2)) begin
									n.write_enable_latch = 1'b0;
									if (r.wp2) begin
										n.protect_bits = (r.nbits == LEN_SR1) ? r.args[6:2] : r.args[14:10];
										n.srp0 = (r.nbits == LEN_SR1) ? r.args[7] : r.args[15];
										if (r.nbits == LEN_SR2) begin
											n.srp1 = r.args[0];
										end
									end
									if (r.nbits == LEN_SR2) begin
										n.per_block_protect_select = r.args[2];
										n.cmp = r.args[6];
									end
								end
							end
							OP_PROGRAM: begin
								if (r.write_enable_latch && r.nbits == LEN_PROGRAM) begin
									n.write_enable_latch = 1'b0;
									if (r.args[31:27] == 5'h0 && !prot_hit(r.protect_bits, r.cmp,
											r.per_block_protect_select, r.args[31:8], r.args[31:8])) begin
										n.st = ST_BUSY;
										n.op_erase = 1'b0;
										n.op_lo = r.args[26:8];
										n.op_hi = r.args[26:8];
										n.op_data = r.args[7:0];
										n.timer = 20'(PROG_CYCLES - 1);
									end
								end
							end
							OP_ERASE_PAGE, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: begin
								if (r.write_enable_latch && r.nbits == LEN_ERASE) begin
									n.write_enable_latch = 1'b0;
									if (t_lo[23:19] == 5'h0 && !prot_hit(r.protect_bits, r.cmp,
											r.per_block_protect_select, t_lo, t_hi)) begin
										n.st = ST_BUSY;
										n.op_erase = 1'b1;
										n.op_lo = t_lo[18:0];
										n.op_hi = t_hi[18:0];
										n.timer = 20'(ERASE_CYCLES - 1);
									end
								end
							end
							OP_ERASE_CHIP, OP_ERASE_CHIP2: begin
								if (r.write_enable_latch && r.nbits == LEN_OP) begin
									n.write_enable_latch = 1'b0;
									if (!prot_hit(r.protect_bits, r.cmp, r.per_block_protect_select, 24'h0, ARRAY_TOP)) begin
										n.st = ST_BUSY;
										n.op_erase = 1'b1;
										n.op_lo = 19'h0;
										n.op_hi = ARRAY_TOP[18:0];
										n.timer = 20'(ERASE_CYCLES - 1);
									end
								end
							end
							default: begin
								n.st = ST_IDLE;
							end
						endcase
					end
				endcase
			end
		end
	end

	// status and state clear to zero and standby on reset
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign link.miso = r.miso;
	assign mem_prog = r.prog_pulse;
	assign mem_prog_addr = r.op_lo;
	assign mem_prog_data = r.op_data;
	assign mem_erase = r.erase_pulse;
	assign mem_erase_lo = r.op_lo;
	assign mem_erase_hi = r.op_hi;
	assign busy = (r.st == ST_BUSY);
	assign suspended = (r.st == ST_SUSP);
	assign deep_pd = r.dpd;
endmodule : fwp_flash_end

// *** fwp_host_end.sv ***
// controller end: AXI4-Lite registers driving the serial flash link
`timescale 1ns/100ps
module fwp_host_end
	import fwp_pkg::*;
#(
	parameter int SELECT_CYCLES = SELECT_DELAY_CYC,
	parameter int GAP_CYCLES = PROGRESS_GAP_CYC,
	parameter int HALF_CYCLES = SCLK_HALF_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// axi4-lite slave
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial link
	fwp_link_if.ctrl link
);
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_WAIT = 3'b001,
		H_SHIFT = 3'b010,
		H_END = 3'b011,
		H_DESEL = 3'b100
	} fwp_host_state_type;

	typedef struct packed {
		logic miso1;
		logic miso2;
		logic aw_got;
		logic [3:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic pending;
		logic [7:0] cmd_op;
		logic [2:0] cmd_n;
		logic [31:0] args;
		logic wp_on;
		logic [7:0] rx;
		fwp_host_state_type st;
		logic [15:0] pon_cnt;
		logic [15:0] gap_cnt;
		logic [7:0] div;
		logic [5:0] nbits;
		logic [39:0] sh;
		logic sclk;
		logic cs_sel;
	} fwp_host_regs_type;

	fwp_host_regs_type r;
	fwp_host_regs_type n;
	logic ready;
	logic tick;
	logic [31:0] status;

	assign ready = (r.pon_cnt == 16'(SELECT_CYCLES));
	assign tick = (r.div == 8'h0);
	assign status = {16'h0, r.rx, 5'h0, r.gap_cnt != 16'h0, ready, r.st != H_IDLE || r.pending};

	always_comb begin
		n = r;
		n.miso1 = link.miso;
		n.miso2 = r.miso1;
		if (!ready) begin
			n.pon_cnt = r.pon_cnt + 16'h1;
		end
		if (r.gap_cnt != 16'h0) begin
			n.gap_cnt = r.gap_cnt - 16'h1;
		end
		if (!tick) begin
			n.div = r.div - 8'h1;
		end
		// write channel: address and data in either order, response after both
		if (s_axi_awvalid && s_axi_awready) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = RESP_OKAY;
			case (r.awaddr)
				REG_CMD: begin
					if (r.st == H_IDLE && !r.pending && r.wdata[10:8] <= 3'h4) begin
						n.cmd_op = r.wdata[7:0];
						n.cmd_n = r.wdata[10:8];
						n.pending = 1'b1;
					end else begin
						n.bresp = RESP_SLVERR;
					end
				end
				REG_ARGS: begin
					for (int i = 0; i < 4; i++) begin
						if (r.wstrb[i]) begin
							n.args[i*8 +: 8] = r.wdata[i*8 +: 8];
						end
					end
				end
				REG_CTRL: begin
					if (r.wstrb[0]) begin
						n.wp_on = r.wdata[0];
					end
				end
				REG_STATUS: begin
					n.bresp = RESP_OKAY;
				end
				default: begin
					n.bresp = RESP_SLVERR;
				end
			endcase
		end
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			n.rvalid = 1'b1;
			n.rresp = RESP_OKAY;
			case (s_axi_araddr)
				REG_CMD: n.rdata = {21'h0, r.cmd_n, r.cmd_op};
				REG_ARGS: n.rdata = r.args;
				REG_CTRL: n.rdata = {31'h0, r.wp_on};
				REG_STATUS: n.rdata = status;
				default: begin
					n.rdata = 32'h0;
					n.rresp = RESP_SLVERR;
				end
			endcase
		end
		case (r.st)
			H_IDLE: begin
				if (r.pending) begin
					n.st = H_WAIT;
				end
			end
			H_WAIT: begin
				// select stays off until power-up delay has run out and, for a suspend command, the resume gap too
				if (ready && !(r.cmd_op == OP_SUSPEND && r.gap_cnt != 16'h0)) begin
					n.pending = 1'b0;
					n.cs_sel = 1'b1;
					n.sh = {r.cmd_op, r.args};
					n.nbits = {r.cmd_n, 3'h0} + LEN_OP;
					n.div = 8'(HALF_CYCLES - 1);
					n.st = H_SHIFT;
				end
			end
			H_SHIFT: begin
				if (tick) begin
					n.div = 8'(HALF_CYCLES - 1);
					n.sclk = !r.sclk;
					if (!r.sclk) begin
						n.rx = {r.rx[6:0], r.miso2};
					end else begin
						n.sh = {r.sh[38:0], 1'b0};
						n.nbits = r.nbits - 6'h1;
						if (r.nbits == 6'h1) begin
							n.st = H_END;
						end
					end
				end
			end
			H_END: begin
				if (tick) begin
					n.cs_sel = 1'b0;
					n.div = 8'(HALF_CYCLES - 1);
					n.st = H_DESEL;
					if (r.cmd_op == OP_RESUME) begin
						n.gap_cnt = 16'(GAP_CYCLES);
					end
				end
			end
			default: begin
				if (tick) begin
					n.st = H_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign s_axi_awready = !r.aw_got && !r.bvalid;
	assign s_axi_wready = !r.w_got && !r.bvalid;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_bresp = r.bresp;
	assign s_axi_arready = !r.rvalid;
	assign s_axi_rvalid = r.rvalid;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rdata = r.rdata;
	assign link.sclk = r.sclk;
	assign link.cs_n = !r.cs_sel;
	assign link.mosi = r.sh[39];
	assign link.wp_n = !r.wp_on;
endmodule : fwp_host_end

// *** fwp_link_props.sv ***
// concurrent checks on the flash link and on the flash end's outputs
`timescale 1ns/100ps
module fwp_link_props
	import fwp_pkg::*;
#(
	parameter int PROG_CYCLES = 40,
	parameter int ERASE_CYCLES = 60,
	parameter int SELECT_CYCLES = 20
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic wp_n,
	// flash end
	input wire logic mem_prog,
	input wire logic mem_erase,
	input wire logic [18:0] mem_erase_lo,
	input wire logic [18:0] mem_erase_hi,
	input wire logic busy,
	input wire logic suspended,
	input wire logic deep_pd
);
	// run counts only unsuspended busy cycles, so a suspended operation keeps its count
	int run;
	int up;
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			run <= 0;
			up <= 0;
		end else begin
			if (up < SELECT_CYCLES)
				up <= up + 1;
			if (!busy && !suspended)
				run <= 0;
			else if (!suspended)
				run <= run + 1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence strobe_s;
		mem_prog || mem_erase;
	endsequence
	sequence closed_s;
		cs_n && $past(cs_n);
	endsequence
	chk_prog_time: assert property (
		mem_prog |-> run >= PROG_CYCLES - 2 && run <= PROG_CYCLES + 2)
		else $error("program strobe after wrong busy time");
	chk_erase_time: assert property (
		mem_erase |-> run >= ERASE_CYCLES - 2 && run <= ERASE_CYCLES + 2)
		else $error("erase strobe after wrong busy time");
	chk_strobe_single: assert property (strobe_s |=> !mem_prog && !mem_erase)
		else $error("array strobe longer than one cycle");
	chk_strobe_end: assert property (strobe_s |-> $past(busy) && !suspended)
		else $error("array strobe without a finished operation");
	chk_busy_start: assert property ($rose(busy) |-> closed_s)
		else $error("operation started inside a frame");
	chk_suspend_hold: assert property ($rose(suspended) |-> $past(busy) && !mem_prog)
		else $error("suspend without running operation");
	chk_sleep_quiet: assert property (deep_pd |-> !busy && !mem_prog && !mem_erase)
		else $error("activity in deep power-down");
	chk_idle_clock: assert property (cs_n |-> !sclk)
		else $error("link clock moves while deselected");
	chk_erase_span: assert property (
		mem_erase |-> mem_erase_lo <= mem_erase_hi && mem_erase_lo[7:0] == 8'h00)
		else $error("erase range malformed");
	chk_select_wait: assert property (!cs_n |-> up >= SELECT_CYCLES - 1)
		else $error("select before power-up delay");
	chk_data_steady: assert property ($changed(mosi) || $changed(miso) |-> !sclk)
		else $error("link data moved while the link clock was high");
endmodule : fwp_link_props

// *** tb.sv ***
// testbench: host and flash ends joined over the link, driven through axi4-lite
`timescale 1ns/100ps
module tb
	import fwp_pkg::*;
;
	localparam int PROG_N = 600;
	localparam int ERASE_N = 800;
	localparam int SEL_N = 20;
	localparam int GAP_N = 50;
	localparam logic [7:0] OPS [8] = '{OP_PROGRAM, OP_ERASE_PAGE, OP_ERASE_4K, OP_ERASE_32K,
		OP_ERASE_64K, OP_ERASE_CHIP, OP_PROGRAM, OP_ERASE_CHIP2};
	localparam int MSK [8] = '{0, 'hff, 'hfff, 'h7fff, 'hffff, 'h7ffff, 0, 'h7ffff};
	localparam logic [2:0] NARG [8] = '{3'h4, 3'h3, 3'h3, 3'h3, 3'h3, 3'h0, 3'h3, 3'h0};
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] s_axi_awaddr = 4'h0;
	logic [3:0] s_axi_araddr = 4'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 32'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata, st, a;
	logic mem_prog, mem_erase, busy, suspended, deep_pd, c, w, ok;
	logic [18:0] mem_prog_addr, mem_erase_lo, mem_erase_hi;
	logic [7:0] mem_prog_data, v, dat;
	logic [4:0] bp;
	int fail_count = 0, checks_done = 0, seed = 32'h7257891b;
	int np = 0, ne = 0, cyc = 0, rise_c = 0, fall_c = 0, lo, hi, kd, p0, e0, r;

	fwp_link_if link ();
	fwp_host_end #(.SELECT_CYCLES(SEL_N), .GAP_CYCLES(GAP_N), .HALF_CYCLES(8)) fwp_host_end_i (
		.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .link(link.ctrl));
	fwp_flash_end #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N)) fwp_flash_end_i (
		.core_clk, .rst, .link(link.flash), .mem_prog, .mem_prog_addr, .mem_prog_data,
		.mem_erase, .mem_erase_lo, .mem_erase_hi, .busy, .suspended, .deep_pd);
	fwp_link_props #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N), .SELECT_CYCLES(SEL_N))
		fwp_link_props_i (.core_clk, .rst, .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi),
		.miso(link.miso), .wp_n(link.wp_n), .mem_prog, .mem_erase, .mem_erase_lo, .mem_erase_hi,
		.busy, .suspended, .deep_pd);

	initial begin
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (mem_prog)
			np <= np + 1;
		if (mem_erase)
			ne <= ne + 1;
	end
	always @(posedge link.cs_n) rise_c = cyc;
	always @(negedge link.cs_n) fall_c = cyc;

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	task automatic wr(input logic [3:0] ad, input logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_awaddr <= ad;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk(s_axi_bresp, er);
	endtask : wr

	task automatic rd(input logic [3:0] ad, output logic [31:0] d, input logic [1:0] er);
		@(posedge core_clk);
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		chk(s_axi_rresp, er);
	endtask : rd

	// one frame: arguments, command, then poll until the host has closed it
	task automatic cmd(input logic [7:0] op, input logic [2:0] n, input logic [31:0] args);
		logic [31:0] s;
		int k;
		if (n != 3'h0)
			wr(REG_ARGS, args, RESP_OKAY);
		wr(REG_CMD, {21'h0, n, op}, RESP_OKAY);
		k = 0;
		s = 32'h1;
		while (s[0] !== 1'b0 && k < 400) begin
			rd(REG_STATUS, s, RESP_OKAY);
			k++;
		end
		chk(s[0], 1'b0);
		// the flash end acts a few clocks after deselect
		repeat (6) @(posedge core_clk);
		chk({link.cs_n, link.sclk}, 2'b10);
	endtask : cmd

	task automatic rdsr(input logic [7:0] op, output logic [7:0] q);
		logic [31:0] s;
		cmd(op, 3'h1, 32'h0);
		rd(REG_STATUS, s, RESP_OKAY);
		q = s[15:8];
	endtask : rdsr

	task automatic expect_op(input logic exp_ok);
		int k;
		k = 0;
		while (np == p0 && ne == e0 && k < ERASE_N + 100) begin
			@(posedge core_clk);
			k++;
		end
		chk(np - p0 + ne - e0, exp_ok);
	endtask : expect_op

	// true when [l, h] touches the protected part of the array
	function automatic logic blocked(logic [4:0] b, logic cm, int l, int h);
		int sz, rl, rh;
		sz = b[4] ? (b[2] ? 'h8000 : 'h1000 << (b[1:0] - 1)) : 'h10000 << (b[1:0] - 1);
		rl = b[3] ? 0 : 'h80000 - sz;
		rh = rl + sz - 1;
		if (b[4] ? b[2:0] == 3'h7 : b[2]) begin
			rl = 0;
			rh = 'h7ffff;
		end
		if (b[2:0] == 3'h0)
			rl = 'h80000;
		return cm ? !(l >= rl && h <= rh) : !(h < rl || l > rh);
	endfunction : blocked

	initial begin
		repeat (90000) @(posedge core_clk);
		fail_count++;
		end_sim();
	end

	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		rd(REG_STATUS, st, RESP_OKAY);
		chk(st[1], 1'b0);
		chk({busy, suspended, deep_pd}, 3'h0);
		rd(4'h2, st, RESP_SLVERR);
		wr(REG_CMD, {21'h0, 3'h5, OP_SET_WE}, RESP_SLVERR);
		rdsr(OP_READ_SR1, v);
		chk(v, 8'h00);
		rdsr(OP_READ_SR2, v);
		chk(v, 8'h00);
		p0 = np;
		e0 = ne;
		cmd(OP_PROGRAM, 3'h4, 32'h0000105a);
		expect_op(1'b0);
		$display("power-up and write-enable test done");
		for (int i = 0; i < 16; i++) begin
			bp = 5'($random(seed));
			c = 1'($random(seed));
			w = (i % 8 == 7);
			kd = i % 8;
			a = $random(seed) & 32'h7ffff;
			dat = 8'($random(seed));
			cmd(OP_SET_WE, 3'h0, 32'h0);
			cmd(OP_WRITE_SR, 3'h2, {1'b0, bp, 2'b00, 1'b0, c, 3'b000, w, 2'b00, 16'h0});
			rdsr(OP_READ_SR1, v);
			chk(v, {1'b0, bp, 2'b00});
			lo = a & ~MSK[kd];
			hi = a | MSK[kd];
			ok = kd != 6 && !w && !blocked(bp, c, lo, hi);
			cmd(OP_SET_WE, 3'h0, 32'h0);
			p0 = np;
			e0 = ne;
			cmd(OPS[kd], NARG[kd], kd == 0 ? {a[23:0], dat} : {a[23:0], 8'h00});
			expect_op(ok);
			if (ok && kd == 0) begin
				chk(mem_prog_addr, a[18:0]);
				chk(mem_prog_data, dat);
			end else if (ok) begin
				chk(mem_erase_lo, lo[18:0]);
				chk(mem_erase_hi, hi[18:0]);
			end
		end
		$display("protection decode test done");
		wr(REG_CTRL, 32'h1, RESP_OKAY);
		chk(link.wp_n, 1'b0);
		cmd(OP_SET_WE, 3'h0, 32'h0);
		cmd(OP_WRITE_SR, 3'h2, 32'h7c400000);
		rdsr(OP_READ_SR1, v);
		chk(v, {1'b0, bp, 2'b00});
		rdsr(OP_READ_SR2, v);
		chk(v, 8'h40);
		wr(REG_CTRL, 32'h0, RESP_OKAY);
		cmd(OP_SET_WE, 3'h0, 32'h0);
		cmd(OP_WRITE_SR, 3'h2, 32'h0);
		$display("write-protect pin test done");
		cmd(OP_DEEP_PD, 3'h0, 32'h0);
		chk(deep_pd, 1'b1);
		cmd(OP_SET_WE, 3'h0, 32'h0);
		p0 = np;
		e0 = ne;
		cmd(OP_PROGRAM, 3'h4, 32'h00010033);
		expect_op(1'b0);
		cmd(OP_RELEASE_PD, 3'h0, 32'h0);
		chk(deep_pd, 1'b0);
		rdsr(OP_READ_SR1, v);
		chk(v, 8'h00);
		$display("deep power-down test done");
		// program first, then erase: the resume gap must hold for both
		for (int j = 0; j < 2; j++) begin
			cmd(OP_SET_WE, 3'h0, 32'h0);
			p0 = np;
			e0 = ne;
			cmd(j ? OP_ERASE_4K : OP_PROGRAM, j ? 3'h3 : 3'h4, 32'h00100077);
			cmd(OP_SUSPEND, 3'h0, 32'h0);
			chk(suspended, 1'b1);
			cmd(OP_RESUME, 3'h0, 32'h0);
			r = rise_c;
			cmd(OP_SUSPEND, 3'h0, 32'h0);
			chk(fall_c - r >= GAP_N, 1'b1);
			chk(suspended, 1'b1);
			cmd(OP_RESUME, 3'h0, 32'h0);
			expect_op(1'b1);
			if (j) begin
				chk(mem_erase_lo, 19'h01000);
				chk(mem_erase_hi, 19'h01fff);
			end else begin
				chk(mem_prog_addr, 19'h01000);
				chk(mem_prog_data, 8'h77);
			end
		end
		$display("suspend and resume test done");
		end_sim();
	end
endmodule : tb
